// file: ioc_io_conditioning.sv
// field i/o conditioning: thermal input, analog output and three relays behind apb
`timescale 1ns/1ps
`include "ioc_cfg.svh"

module ioc_io_conditioning
  import ioc_pkg::*;
#(
  parameter int TICK_CYCLES = `IOC_TICK_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CTRL_SUPPLY_OK,
  input wire logic ERROR_DET,
  input wire logic MAINS_CMD,
  input wire logic [`IOC_TRG_COUNT-1:0] COND,
  input wire ioc_src_bus_t SRC_VAL,
  input wire logic [15:0] THERM_RAW,
  output logic RELAY_ONE,
  output logic [1:0] RELAY_OUT,
  output logic [15:0] AO_LEVEL,
  output logic AO_IS_VOLTAGE,
  output logic THERM_ERROR
);

  // ************************************************
  // helpers
  // ************************************************
  // clamp a written value into its settable range
  function automatic logic [15:0] ioc_sat(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] r;
    r = v[15:0];
    if (v > {16'h0000, hi}) begin
      r = hi;
    end else if (v < {16'h0000, lo}) begin
      r = lo;
    end
    return r;
  endfunction

  // first-order low pass, one step per tick; n = time constant in ticks, zero passes through
  function automatic logic [15:0] ioc_lpf(input logic [15:0] y, input logic [15:0] x, input logic [13:0] n);
    logic signed [17:0] d;
    logic signed [17:0] s;
    d = $signed({2'b00, x}) - $signed({2'b00, y});
    s = 18'sh00000;
    if (n != 14'h0000) begin
      s = d / $signed({4'h0, n});
      // a step below one count would stall short of the target, so nudge it
      if (s == 18'sh00000 && d != 18'sh00000) begin
        s = (d < 18'sh00000) ? -18'sh00001 : 18'sh00001;
      end
    end
    return (n == 14'h0000) ? x : 16'(y + s[15:0]);
  endfunction

  // ************************************************
  // register state
  // ************************************************
  logic ai_assign_reg; // thermal_input_assign
  logic [2:0] ai_type_reg; // thermal_input_sensor_type
  logic [15:0] ai_filt_reg; // thermal_input_filter_time, 10 ms units
  logic [15:0] ai_limit_reg; // overheat threshold on the filtered value
  logic [2:0] ao_src_reg; // analog_out_source
  logic [15:0] ao_gain_reg; // analog_out_gain_pct
  logic ao_volt_reg; // analog_out_signal_type, 1 = voltage
  ioc_range_s ao_cur_reg; // analog_out_current_min / max
  ioc_range_s ao_volt_rng_reg; // analog_out_voltage_min / max
  logic [15:0] ao_slo_reg; // analog_out_scale_low
  logic [15:0] ao_shi_reg; // analog_out_scale_high
  logic [15:0] ao_filt_reg; // analog_out_filter_time, ms
  logic [1:0] r1_assign_reg; // relay_one_assign
  ioc_relay_cfg_s rly_cfg_reg [2]; // relay two / three settings
  logic [15:0] ai_value_reg; // thermal_value, also thermal_input_standard_value
  logic therm_err_reg; // overheat detected
  logic [31:0] rdata_reg; // read data captured in setup phase
  logic slverr_reg; // unmapped address seen in setup phase
  logic [16:0] tick_cnt_reg; // millisecond divider
  logic tick_reg; // one-cycle ms strobe

  // ************************************************
  // apb slave
  // ************************************************
  logic wr_en; // write strobe in the access phase
  logic chan; // relay channel picked by address bit 2
  logic [7:0] pair_addr; // address with the channel bit cleared
  logic [31:0] rd_data; // read mux
  logic rd_hit; // address is mapped
  logic [31:0] status_word; // live status
  logic [15:0] ai_max_time; // ai filter limit in 10 ms units

  // the slave never inserts waits, but a low clock enable stretches the access phase
  assign PREADY = PSEL & PENABLE & CE;
  assign PRDATA = rdata_reg;
  assign PSLVERR = slverr_reg & PREADY;
  assign wr_en = PREADY & PWRITE & ~slverr_reg;
  assign chan = PADDR[2];
  assign pair_addr = {PADDR[7:3], 3'b000};
  assign ai_max_time = `IOC_AI_FILT_MAX;
  assign status_word = {AO_LEVEL, 12'h000, therm_err_reg, RELAY_OUT, RELAY_ONE};

  // read mux and decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (PADDR)
      `IOC_A_AI_ASSIGN: rd_data = {31'h0, ai_assign_reg};
      `IOC_A_AI_TYPE: rd_data = {29'h0, ai_type_reg};
      `IOC_A_AI_FILT: rd_data = {16'h0, ai_filt_reg};
      `IOC_A_AI_STD: rd_data = {16'h0, ai_value_reg};
      `IOC_A_AI_LIMIT: rd_data = {16'h0, ai_limit_reg};
      `IOC_A_AO_SRC: rd_data = {29'h0, ao_src_reg};
      `IOC_A_AO_GAIN: rd_data = {16'h0, ao_gain_reg};
      `IOC_A_AO_TYPE: rd_data = {31'h0, ao_volt_reg};
      `IOC_A_AO_CMIN: rd_data = {16'h0, ao_cur_reg.lo};
      `IOC_A_AO_VMIN: rd_data = {16'h0, ao_volt_rng_reg.lo};
      `IOC_A_AO_CMAX: rd_data = {16'h0, ao_cur_reg.hi};
      `IOC_A_AO_VMAX: rd_data = {16'h0, ao_volt_rng_reg.hi};
      `IOC_A_AO_SLO: rd_data = {16'h0, ao_slo_reg};
      `IOC_A_AO_SHI: rd_data = {16'h0, ao_shi_reg};
      `IOC_A_AO_FILT: rd_data = {16'h0, ao_filt_reg};
      `IOC_A_R1_ASSIGN: rd_data = {30'h0, r1_assign_reg};
      `IOC_A_STATUS: rd_data = status_word;
      default: begin
        // channel pairs share one decode
        case (pair_addr)
          `IOC_A_RLY_ASSIGN: rd_data = {26'h0, rly_cfg_reg[chan].code};
          `IOC_A_RLY_DELAY: rd_data = {16'h0, rly_cfg_reg[chan].delay};
          `IOC_A_RLY_POL: rd_data = {31'h0, rly_cfg_reg[chan].active_low};
          `IOC_A_RLY_HOLD: rd_data = {16'h0, rly_cfg_reg[chan].hold};
          default: rd_hit = 1'b0;
        endcase
      end
    endcase
  end

  // capture read data and the error answer in the setup phase
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (CE && PSEL && !PENABLE) begin
      rdata_reg <= PWRITE ? 32'h0000_0000 : rd_data;
      slverr_reg <= ~rd_hit;
    end
  end

  // configuration writes, numeric settings other than the overheat limit saturated to their range, out-of-list codes ignored
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ai_assign_reg <= 1'b0;
      ai_type_reg <= IOC_SNS_NONE;
      ai_filt_reg <= 16'h0000;
      ai_limit_reg <= `IOC_AI_LIMIT_DEF;
      ao_src_reg <= IOC_SRC_CURRENT;
      ao_gain_reg <= `IOC_GAIN_DEF;
      ao_volt_reg <= 1'b0;
      ao_cur_reg <= '{lo: 16'h0000, hi: `IOC_CUR_FULL};
      ao_volt_rng_reg <= '{lo: 16'h0000, hi: `IOC_VOLT_FULL};
      ao_slo_reg <= 16'h0000;
      ao_shi_reg <= `IOC_PCT_MAX;
      ao_filt_reg <= 16'h0000;
      r1_assign_reg <= `IOC_R1_OPFAULT;
      for (int i = 0; i < 2; i++) begin
        rly_cfg_reg[i] <= '{code: `IOC_TRG_NONE, delay: 16'h0000, hold: 16'h0000, active_low: 1'b0};
      end
    end else if (CE && wr_en) begin
      case (PADDR)
        `IOC_A_AI_ASSIGN: ai_assign_reg <= PWDATA[0];
        `IOC_A_AI_TYPE: begin
          // sensor type only takes while the input is assigned
          if (ai_assign_reg && PWDATA[2:0] <= IOC_SNS_PT100_3W) begin
            ai_type_reg <= PWDATA[2:0];
          end
        end
        `IOC_A_AI_FILT: begin
          if (ai_assign_reg) begin
            ai_filt_reg <= ioc_sat(PWDATA, 16'h0000, ai_max_time);
          end
        end
        `IOC_A_AI_LIMIT: ai_limit_reg <= PWDATA[15:0];
        `IOC_A_AO_SRC: begin
          if (PWDATA[2:0] <= IOC_SRC_REACTIVE) begin
            ao_src_reg <= PWDATA[2:0];
          end
        end
        `IOC_A_AO_GAIN: ao_gain_reg <= ioc_sat(PWDATA, `IOC_GAIN_MIN, `IOC_GAIN_MAX);
        `IOC_A_AO_TYPE: ao_volt_reg <= PWDATA[0];
        `IOC_A_AO_CMIN: ao_cur_reg.lo <= ioc_sat(PWDATA, 16'h0000, `IOC_CUR_FULL);
        `IOC_A_AO_VMIN: ao_volt_rng_reg.lo <= ioc_sat(PWDATA, 16'h0000, `IOC_VOLT_FULL);
        `IOC_A_AO_CMAX: ao_cur_reg.hi <= ioc_sat(PWDATA, 16'h0000, `IOC_CUR_FULL);
        `IOC_A_AO_VMAX: ao_volt_rng_reg.hi <= ioc_sat(PWDATA, 16'h0000, `IOC_VOLT_FULL);
        `IOC_A_AO_SLO: ao_slo_reg <= ioc_sat(PWDATA, 16'h0000, `IOC_PCT_MAX);
        `IOC_A_AO_SHI: ao_shi_reg <= ioc_sat(PWDATA, 16'h0000, `IOC_PCT_MAX);
        `IOC_A_AO_FILT: ao_filt_reg <= ioc_sat(PWDATA, 16'h0000, `IOC_AO_FILT_MAX);
        `IOC_A_R1_ASSIGN: begin
          if (PWDATA[1:0] <= `IOC_R1_MAINS) begin
            r1_assign_reg <= PWDATA[1:0];
          end
        end
        default: begin
          case (pair_addr)
            `IOC_A_RLY_ASSIGN: begin
              // out-of-list codes, and end-of-start on relay three, are ignored
              if (PWDATA[5:0] < 6'(`IOC_TRG_COUNT) && !(chan && PWDATA[5:0] == `IOC_TRG_EOS)) begin
                rly_cfg_reg[chan].code <= PWDATA[5:0];
              end
            end
            `IOC_A_RLY_DELAY: rly_cfg_reg[chan].delay <= ioc_sat(PWDATA, 16'h0000, `IOC_DELAY_MAX);
            `IOC_A_RLY_POL: rly_cfg_reg[chan].active_low <= PWDATA[0];
            `IOC_A_RLY_HOLD: rly_cfg_reg[chan].hold <= ioc_sat(PWDATA, 16'h0000, `IOC_HOLD_MAX);
            default: ;
          endcase
        end
      endcase
    end
  end

  // ************************************************
  // millisecond timebase
  // ************************************************
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      tick_cnt_reg <= 17'h00000;
      tick_reg <= 1'b0;
    end else if (CE) begin
      tick_reg <= (tick_cnt_reg == 17'(TICK_CYCLES - 1));
      tick_cnt_reg <= (tick_cnt_reg == 17'(TICK_CYCLES - 1)) ? 17'h00000 : 17'(tick_cnt_reg + 17'h00001);
    end
  end

  // ************************************************
  // thermal input
  // ************************************************
  logic [13:0] ai_time_ticks; // filter constant in ms

  assign ai_time_ticks = 14'(ai_filt_reg[13:0] * `IOC_AI_FILT_UNIT);
  assign THERM_ERROR = therm_err_reg;

  // filter the sensor reading; unassigned, the input is dead and reads zero
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ai_value_reg <= 16'h0000;
      therm_err_reg <= 1'b0;
    end else if (CE) begin
      if (!ai_assign_reg || ai_type_reg == IOC_SNS_NONE) begin
        ai_value_reg <= 16'h0000;
        therm_err_reg <= 1'b0;
      end else begin
        if (tick_reg) begin
          ai_value_reg <= ioc_lpf(ai_value_reg, THERM_RAW, ai_time_ticks);
        end
        therm_err_reg <= (ai_value_reg > ai_limit_reg);
      end
    end
  end

  // ************************************************
  // analog output
  // ************************************************
  logic [15:0] gain_eff; // gain after forcing
  logic [15:0] src_sel; // selected source value
  logic [15:0] slo_eff; // low scale after equalising
  logic [15:0] shi_eff; // high scale
  logic [39:0] img_num; // source times image scale
  logic [39:0] img_den; // nominal times gain
  logic [39:0] img_quot; // raw image in 0.1 percent
  logic [15:0] img_reg; // clipped image, 0..1000
  ioc_range_s out_rng; // level range of the active type
  logic [15:0] lo_img; // scale low in image units
  logic [15:0] hi_img; // scale high in image units
  logic signed [39:0] span_prod; // level span times position
  logic signed [39:0] map_val; // mapped level
  logic [15:0] map_reg; // mapped level, registered
  logic [15:0] ao_level_reg; // filtered output level

  // the forced gains put full scale where the source naturally saturates
  always_comb begin
    case (ao_src_reg)
      IOC_SRC_PF: gain_eff = `IOC_GAIN_PF;
      IOC_SRC_THERMAL: gain_eff = `IOC_GAIN_TH;
      default: gain_eff = ao_gain_reg;
    endcase
  end

  assign src_sel = (ao_src_reg == IOC_SRC_NONE) ? 16'h0000 : SRC_VAL[3'(ao_src_reg - 3'b001)];
  assign slo_eff = (ao_slo_reg > ao_shi_reg) ? ao_shi_reg : ao_slo_reg;
  assign shi_eff = ao_shi_reg;
  assign img_num = {24'h000000, src_sel} * `IOC_IMG_SCALE;
  assign img_den = {24'h000000, gain_eff} * `IOC_SRC_NOMINAL;
  assign img_quot = img_num / img_den;
  assign out_rng = ao_volt_reg ? ao_volt_rng_reg : ao_cur_reg;
  assign lo_img = 16'(slo_eff * `IOC_PCT_TO_IMG);
  assign hi_img = 16'(shi_eff * `IOC_PCT_TO_IMG);

  // linear map from the scale window onto the level range, flat outside it
  always_comb begin
    span_prod = ($signed({24'h000000, out_rng.hi}) - $signed({24'h000000, out_rng.lo}))
              * $signed({24'h000000, 16'(img_reg - lo_img)});
    if (img_reg <= lo_img) begin
      map_val = $signed({24'h000000, out_rng.lo});
    end else if (img_reg >= hi_img) begin
      map_val = $signed({24'h000000, out_rng.hi});
    end else begin
      map_val = $signed({24'h000000, out_rng.lo}) + span_prod / $signed({24'h000000, 16'(hi_img - lo_img)});
    end
  end

  // two-stage pipeline keeps the dividers off one path
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      img_reg <= 16'h0000;
      map_reg <= 16'h0000;
    end else if (CE) begin
      img_reg <= (img_quot > {24'h000000, `IOC_IMG_FULL}) ? `IOC_IMG_FULL : img_quot[15:0];
      map_reg <= (ao_src_reg == IOC_SRC_NONE) ? 16'h0000 : map_val[15:0];
    end
  end

  // output filter steps once a millisecond
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ao_level_reg <= 16'h0000;
    end else if (CE && tick_reg) begin
      ao_level_reg <= ioc_lpf(ao_level_reg, map_reg, ao_filt_reg[13:0]);
    end
  end

  assign AO_LEVEL = ao_level_reg;
  assign AO_IS_VOLTAGE = ao_volt_reg;

  // ************************************************
  // relays
  // ************************************************
  logic op_ok; // supplied and no error of any kind
  logic [`IOC_TRG_COUNT-1:0] cond_vec; // conditions with internal ones merged
  logic relay_one_reg; // relay one contact

  assign op_ok = CTRL_SUPPLY_OK & ~ERROR_DET & ~therm_err_reg;

  // internal conditions override the matching external lines
  always_comb begin
    cond_vec = COND;
    cond_vec[`IOC_TRG_NONE] = 1'b0;
    cond_vec[`IOC_TRG_OPFAULT] = op_ok;
    cond_vec[`IOC_TRG_MAINS] = MAINS_CMD;
  end

  // relay one follows its trigger with no timing
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      relay_one_reg <= 1'b0;
    end else if (CE) begin
      case (r1_assign_reg)
        `IOC_R1_OPFAULT: relay_one_reg <= op_ok;
        `IOC_R1_MAINS: relay_one_reg <= MAINS_CMD;
        default: relay_one_reg <= 1'b0;
      endcase
    end
  end

  assign RELAY_ONE = relay_one_reg;

  // relay two and three: delay on activation, hold on any change, polarity at the pin
  for (genvar c = 0; c < 2; c++) begin : g_rly
    logic forced; // trigger forbids timing and inversion
    logic cmd; // commanded state
    logic cmd_last_reg; // previous command, restarts the timer
    logic state_reg; // carried-out state
    logic out_reg; // pin level
    ioc_rly_st_e st_reg; // timer state
    logic [16:0] cnt_reg; // elapsed ms
    logic [16:0] wait_ms; // ms to wait for this change

    assign forced = (rly_cfg_reg[c].code == `IOC_TRG_EOS) || (rly_cfg_reg[c].code == `IOC_TRG_MAINS)
                 || (rly_cfg_reg[c].code == `IOC_TRG_OPFAULT) || (rly_cfg_reg[c].code == `IOC_TRG_FWDREV);
    assign cmd = cond_vec[rly_cfg_reg[c].code];
    // activation waits delay plus hold; release waits hold only
    assign wait_ms = forced ? 17'h00000
                   : (cmd ? 17'({1'b0, rly_cfg_reg[c].delay} + {1'b0, rly_cfg_reg[c].hold})
                          : {1'b0, rly_cfg_reg[c].hold});

    // timer state machine
    always_ff @(posedge SYS_CLK) begin
      if (RST) begin
        cmd_last_reg <= 1'b0;
        state_reg <= 1'b0;
        st_reg <= IOC_RLY_STEADY;
        cnt_reg <= 17'h00000;
      end else if (CE) begin
        cmd_last_reg <= cmd;
        if (cmd != cmd_last_reg) begin
          st_reg <= IOC_RLY_PENDING;
          cnt_reg <= 17'h00000;
        end else begin
          case (st_reg)
            IOC_RLY_STEADY: begin
              if (cmd != state_reg) begin
                st_reg <= IOC_RLY_PENDING;
                cnt_reg <= 17'h00000;
              end
            end
            IOC_RLY_PENDING: begin
              if (cnt_reg >= wait_ms) begin
                state_reg <= cmd;
                st_reg <= IOC_RLY_STEADY;
              end else if (tick_reg) begin
                cnt_reg <= 17'(cnt_reg + 17'h00001);
              end
            end
            default: st_reg <= IOC_RLY_STEADY;
          endcase
        end
      end
    end

    // pin level; specials always run active high
    always_ff @(posedge SYS_CLK) begin
      if (RST) begin
        out_reg <= 1'b0;
      end else if (CE) begin
        out_reg <= state_reg ^ (rly_cfg_reg[c].active_low & ~forced);
      end
    end

    assign RELAY_OUT[c] = out_reg;
  end

endmodule // ioc_io_conditioning

// file: ioc_cfg.svh
// constants for the field i/o conditioning block: timing, register offsets, defaults, limits
`ifndef IOC_CFG_SVH
`define IOC_CFG_SVH
// ************************************************
// timing
// ************************************************
`define IOC_CLK_HZ 40000000
`define IOC_TICK_US 1000
`define IOC_TICK_CYCLES ((`IOC_CLK_HZ / 1000000) * `IOC_TICK_US)
// ************************************************
// register byte offsets
// ************************************************
`define IOC_A_AI_ASSIGN 8'h00
`define IOC_A_AI_TYPE 8'h04
`define IOC_A_AI_FILT 8'h08
`define IOC_A_AI_STD 8'h0c
`define IOC_A_AI_LIMIT 8'h10
`define IOC_A_AO_SRC 8'h14
`define IOC_A_AO_GAIN 8'h18
`define IOC_A_AO_TYPE 8'h1c
`define IOC_A_AO_CMIN 8'h20
`define IOC_A_AO_VMIN 8'h24
`define IOC_A_AO_CMAX 8'h28
`define IOC_A_AO_VMAX 8'h2c
`define IOC_A_AO_SLO 8'h30
`define IOC_A_AO_SHI 8'h34
`define IOC_A_AO_FILT 8'h38
`define IOC_A_R1_ASSIGN 8'h3c
`define IOC_A_RLY_ASSIGN 8'h40
`define IOC_A_RLY_DELAY 8'h48
`define IOC_A_RLY_POL 8'h50
`define IOC_A_RLY_HOLD 8'h58
`define IOC_A_STATUS 8'h60
// ************************************************
// defaults and limits (analog levels in 0.01 ma / 0.01 v)
// ************************************************
`define IOC_GAIN_DEF 16'd200
`define IOC_GAIN_MIN 16'd50
`define IOC_GAIN_MAX 16'd700
`define IOC_GAIN_PF 16'd100
`define IOC_GAIN_TH 16'd300
`define IOC_CUR_FULL 16'd2000
`define IOC_VOLT_FULL 16'd1000
`define IOC_PCT_MAX 16'd100
`define IOC_AO_FILT_MAX 16'd10000
`define IOC_AI_FILT_MAX 16'd1000
`define IOC_AI_FILT_UNIT 14'd10
`define IOC_DELAY_MAX 16'd60000
`define IOC_HOLD_MAX 16'd9999
`define IOC_AI_LIMIT_DEF 16'hffff
`define IOC_SRC_NOMINAL 40'd4096
`define IOC_IMG_SCALE 40'd100000
`define IOC_IMG_FULL 16'd1000
`define IOC_PCT_TO_IMG 16'd10
// ************************************************
// trigger codes
// ************************************************
`define IOC_TRG_NONE 6'd0
`define IOC_TRG_OPFAULT 6'd1
`define IOC_TRG_MAINS 6'd11
`define IOC_TRG_EOS 6'd25
`define IOC_TRG_FWDREV 6'd27
`define IOC_TRG_COUNT 38
`define IOC_R1_NONE 2'd0
`define IOC_R1_OPFAULT 2'd1
`define IOC_R1_MAINS 2'd2
`endif

// file: ioc_pkg.sv
// types shared by the field i/o conditioning block
package ioc_pkg;
  // relay channel configuration as stored
  typedef struct packed {
    logic [5:0] code;
    logic [15:0] delay;
    logic [15:0] hold;
    logic active_low;
  } ioc_relay_cfg_s;
  // an analog level range
  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
  } ioc_range_s;
  // six measured sources, each 4096 = nominal
  typedef logic [5:0][15:0] ioc_src_bus_t;
  typedef enum logic [0:0] {IOC_RLY_STEADY = 1'b0, IOC_RLY_PENDING = 1'b1} ioc_rly_st_e;
  typedef enum logic [2:0] {
    IOC_SRC_NONE = 3'b000, IOC_SRC_CURRENT = 3'b001, IOC_SRC_POWER = 3'b010, IOC_SRC_THERMAL = 3'b011,
    IOC_SRC_PF = 3'b100, IOC_SRC_TORQUE = 3'b101, IOC_SRC_REACTIVE = 3'b110
  } ioc_src_e;
  typedef enum logic [2:0] {
    IOC_SNS_NONE = 3'b000, IOC_SNS_PTC = 3'b001, IOC_SNS_KTY = 3'b010, IOC_SNS_PT1000 = 3'b011,
    IOC_SNS_PT100 = 3'b100, IOC_SNS_PT1000_3W = 3'b101, IOC_SNS_PT100_3W = 3'b110
  } ioc_sensor_e;
endpackage

// file: ioc_io_conditioning_asserts.sv
// port assertions for the field i/o conditioning block
`timescale 1ns/1ps
module ioc_io_conditioning_asserts (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CTRL_SUPPLY_OK,
  input wire logic ERROR_DET,
  input wire logic MAINS_CMD,
  input wire logic RELAY_ONE,
  input wire logic [1:0] RELAY_OUT,
  input wire logic [15:0] AO_LEVEL,
  input wire logic THERM_ERROR
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // zero-wait slave: ready in the first access cycle that has the clock enable high
  AST_RDY: assert property (PREADY == (PSEL && PENABLE && CE)) else $error("ready off");
  AST_ERR: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  // relay one closes only from supply or the line command
  AST_R1_SUP: assert property (RELAY_ONE |-> $past(CTRL_SUPPLY_OK) || $past(MAINS_CMD))
    else $error("relay one closed unsupplied");
  AST_R1_ERR: assert property (RELAY_ONE && $past(ERROR_DET) |-> $past(MAINS_CMD))
    else $error("relay one closed on error");
  AST_AO_MAX: assert property (AO_LEVEL <= 16'd2000) else $error("level above range");
  // a stopped clock enable freezes all state
  AST_FRZ_R: assert property (!CE |=> $stable(RELAY_OUT) && $stable(RELAY_ONE)) else $error("relay moved");
  AST_FRZ_A: assert property (!CE |=> $stable(AO_LEVEL)) else $error("level moved");
  AST_FRZ_T: assert property (!CE |=> $stable(THERM_ERROR)) else $error("overheat moved");
  AST_COV_ERR: cover property (PSLVERR);
  AST_COV_R1: cover property ($rose(RELAY_ONE));
  AST_COV_R2: cover property ($rose(RELAY_OUT[0]));
  AST_COV_R3: cover property ($fell(RELAY_OUT[1]));
endmodule // ioc_io_conditioning_asserts
bind ioc_io_conditioning ioc_io_conditioning_asserts i_ioc_io_conditioning_asserts (.*);

// file: ioc_field_model.sv
// field side model: motor measurements and thermal sensor
`timescale 1ns/1ps
module ioc_field_model
  import ioc_pkg::*;
(
  input wire logic [15:0] load,
  input wire logic [15:0] temp,
  output ioc_src_bus_t src,
  output logic [15:0] raw
);
  // all six sources show one load, 4096 = nominal
  assign src = {6{load}};
  // sensor on the thermal_input_terminal reports motor temperature
  assign raw = temp;
endmodule // ioc_field_model

// file: ioc_io_conditioning_test.sv
// self-checking bench for the field i/o conditioning block
`timescale 1ns/1ps
module ioc_io_conditioning_test
  import ioc_pkg::*;
;
  logic SYS_CLK = 0, RST = 1, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, er;
  logic CTRL_SUPPLY_OK = 1, ERROR_DET = 0, MAINS_CMD = 0, PREADY, PSLVERR, RELAY_ONE, AO_IS_VOLTAGE, THERM_ERROR;
  logic [7:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  logic [37:0] COND = 0;
  logic [15:0] load = 16'h1000, temp = 0, THERM_RAW, AO_LEVEL;
  logic [1:0] RELAY_OUT;
  ioc_src_bus_t SRC_VAL;
  int n_mismatch = 0, checks = 0, cyc = 0;
  // short tick: one ms is ten clocks
  ioc_io_conditioning #(.TICK_CYCLES(10)) i_ioc_io_conditioning (.SYS_CLK, .RST, .CE, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CTRL_SUPPLY_OK, .ERROR_DET, .MAINS_CMD, .COND, .SRC_VAL,
    .THERM_RAW, .RELAY_ONE, .RELAY_OUT, .AO_LEVEL, .AO_IS_VOLTAGE, .THERM_ERROR);
  ioc_field_model i_ioc_field_model (.load, .temp, .src(SRC_VAL), .raw(THERM_RAW));
  initial forever #12.5 SYS_CLK = ~SYS_CLK;
  // hang guard
  always @(posedge SYS_CLK) if (++cyc == 20000) begin
    n_mismatch++;
    wrap_up();
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge SYS_CLK) PENABLE <= 1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    rd = PRDATA; er = PSLVERR; PSEL <= 0; PENABLE <= 0;
    @(posedge SYS_CLK);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  task automatic ms(input int n);
    repeat (n * 10) @(posedge SYS_CLK);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge SYS_CLK);
    RST <= 0;
    rc(8'h14, 1);
    rc(8'h28, 2000);
    rc(8'h2c, 1000);
    rc(8'h40, 0);
    rc(8'h48, 0);
    rc(8'h58, 0);
    rc(8'h50, 0);
    apb(0, 8'h64, 0);
    chk(er, 1);
    apb(1, 8'h18, 800);
    rc(8'h18, 700);
    apb(1, 8'h18, 10);
    rc(8'h18, 50);
    apb(1, 8'h04, 2);
    rc(8'h04, 0);
    apb(1, 8'h44, 25);
    rc(8'h44, 0);
    // analog chain: full load at 200 percent gives half range
    apb(1, 8'h18, 200);
    ms(3);
    chk(AO_LEVEL, 1000);
    apb(1, 8'h1c, 1);
    chk(AO_IS_VOLTAGE, 1);
    ms(3);
    chk(AO_LEVEL, 500);
    apb(1, 8'h14, 4);
    ms(3);
    chk(AO_LEVEL, 1000);
    apb(1, 8'h14, 1);
    apb(1, 8'h24, 200);
    ms(3);
    chk(AO_LEVEL, 600);
    // scale low above scale high collapses the window onto high, stored value kept
    apb(1, 8'h30, 60);
    apb(1, 8'h34, 40);
    ms(3);
    chk(AO_LEVEL, 1000);
    rc(8'h30, 60);
    // forced trigger ignores delay and polarity
    apb(1, 8'h48, 5);
    apb(1, 8'h50, 1);
    apb(1, 8'h40, 27);
    COND[27] <= 1;
    repeat (5) @(posedge SYS_CLK);
    chk(RELAY_OUT[0], 1);
    // relay three: active low, 3 ms delay plus 2 ms hold
    apb(1, 8'h44, 5);
    apb(1, 8'h4c, 3);
    apb(1, 8'h5c, 2);
    apb(1, 8'h54, 1);
    // the pin register picks up the new polarity one edge after the write
    @(posedge SYS_CLK);
    chk(RELAY_OUT[1], 1);
    COND[5] <= 1;
    ms(4);
    chk(RELAY_OUT[1], 1);
    ms(3);
    chk(RELAY_OUT[1], 0);
    COND[5] <= 0;
    ms(1);
    chk(RELAY_OUT[1], 0);
    ms(3);
    chk(RELAY_OUT[1], 1);
    chk(RELAY_ONE, 1);
    ERROR_DET <= 1;
    ms(1);
    chk(RELAY_ONE, 0);
    apb(1, 8'h3c, 2);
    MAINS_CMD <= 1;
    ms(1);
    chk(RELAY_ONE, 1);
    apb(1, 8'h3c, 1);
    MAINS_CMD <= 0;
    ERROR_DET <= 0;
    // overheat opens relay one
    apb(1, 8'h00, 1);
    apb(1, 8'h04, 1);
    apb(1, 8'h10, 100);
    temp <= 200;
    ms(3);
    chk(THERM_ERROR, 1);
    rc(8'h0c, 200);
    chk(RELAY_ONE, 0);
    // a stopped clock enable holds the error although the motor has cooled
    CE <= 0;
    temp <= 0;
    repeat (4) @(posedge SYS_CLK);
    chk(THERM_ERROR, 1);
    CE <= 1;
    ms(2);
    chk(THERM_ERROR, 0);
    chk(RELAY_ONE, 1);
    CTRL_SUPPLY_OK <= 0;
    ms(1);
    chk(RELAY_ONE, 0);
    wrap_up();
  end
endmodule // ioc_io_conditioning_test
